// [logic/lic_top.v]
// Purpose: local interrupt routing, backplane irq gating, status lights, timer, bus release
// Assumes: all inputs except the async reset i_rst_b synchronous to i_core_clk; one request is presented at a time
// Notes:   configuration is plain ports held by the host side
`include "lic_map.vh"
`default_nettype none
module lic_top (
  input  wire        i_core_clk,       // board clock
  input  wire        i_rst_b,          // async reset, active low
  input  wire [7:0]  i_src_req,        // local sources, level high, index per map
  input  wire [1:0]  i_ser1_cause,     // serial 1 vector select 0..2
  input  wire [1:0]  i_ser2_cause,     // serial 2 vector select 0..2
  input  wire [23:0] i_src_lvl,        // 3-bit cpu level per source
  input  wire [63:0] i_src_vec,        // 8-bit vector per source
  input  wire [31:0] i_ser_vec,        // extra vectors: ser1 v1,v2 then ser2 v1,v2
  input  wire [7:1]  i_bp_irq,         // backplane irq levels, high = asserted
  input  wire [7:1]  i_bp_irq_en,      // software enable per backplane level
  input  wire        i_iack,           // cpu acknowledges current request
  input  wire        i_acfail_b,       // backplane power fail, low active
  input  wire        i_sysfail_b,      // backplane system fail, low active
  input  wire [5:0]  i_led_set,        // software light bits
  input  wire        i_tmr_load,       // pulse: load counter and prescale
  input  wire [23:0] i_tmr_preset,     // counter reload value
  input  wire [4:0]  i_tmr_prescale,   // prescale divisor minus one
  input  wire        i_tmr_run,        // counter runs while high
  input  wire        i_tmr_ack,        // pulse: clear timer event
  input  wire [1:0]  i_rel_mode,       // bus release mode
  input  wire        i_bus_want,       // local master needs the backplane
  input  wire        i_bus_done,       // local master finished its cycle
  input  wire        i_bus_clear,      // backplane bus clear seen
  input  wire        i_bus_req_other,  // another master requests
  input  wire        i_sysctl,         // board acts as system controller
  input  wire        i_arb_req,        // level request line seen by arbiter
  input  wire        i_arb_busy,       // bus busy line
  input  wire [1:0]  i_int_req,        // pulse: raise interrupter request
  input  wire [5:0]  i_int_lvl,        // 3-bit level per interrupter
  input  wire [1:0]  i_int_ack,        // pulse: interrupter acknowledged
  output reg  [2:0]  o_cpu_ipl,        // pending level, 0 = none
  output reg  [7:0]  o_cpu_vec,        // vector for pending request
  output reg         o_cpu_bp,         // pending request is backplane (autovector)
  output reg  [1:0]  o_fail_stat,      // {sysfail, acfail}, high = failed
  output reg  [5:0]  o_led,            // front panel lights
  output reg  [23:0] o_tmr_count,      // current counter value
  output reg         o_tmr_event,      // sticky timer expiry
  output reg         o_bus_own,        // board owns the backplane
  output reg         o_arb_grant,      // arbiter grant out
  output reg  [13:0] o_int_irq_lvl     // per interrupter level driven, 0 = idle
);
  reg  [4:0]  pre;
  reg  [7:0]  release_after_timeout;
  reg  [2:0]  best_lvl;
  reg  [7:0]  best_vec;
  reg         best_bp;
  reg  [2:0]  l;
  reg  [7:0]  v;
  integer     k;
  wire [7:0]  bp_en_ext;
  wire        bp_gone;
  wire        tmr_expire;
  wire [7:0]  src_live;
  wire [63:0] src_vec_eff;
  genvar      s;

  // a serial source answers with one of three vectors chosen by its cause
  generate
    for (s = 0; s < `LIC_NSRC; s = s + 1) begin : g_src
      wire [1:0] cause;
      wire [7:0] alt1;
      wire [7:0] alt2;
      assign cause = (s == `LIC_SRC_SER1) ? i_ser1_cause :
                     (s == `LIC_SRC_SER2) ? i_ser2_cause : 2'h0;
      assign alt1  = (s == `LIC_SRC_SER1) ? i_ser_vec[7:0] : i_ser_vec[23:16];
      assign alt2  = (s == `LIC_SRC_SER1) ? i_ser_vec[15:8] : i_ser_vec[31:24];
      assign src_vec_eff[s*8 +: 8] = (cause == 2'h1) ? alt1 :
                                     (cause == 2'h2) ? alt2 : i_src_vec[s*8 +: 8];
      // timer source is the sticky event, not an input line
      assign src_live[s] = (s == `LIC_SRC_TIMER) ? o_tmr_event : i_src_req[s];
    end
  endgenerate

  // a presented backplane level whose enable is withdrawn is dropped at once
  assign bp_en_ext = {i_bp_irq_en, 1'b0};
  assign bp_gone   = o_cpu_bp && !bp_en_ext[o_cpu_ipl];

  // combinational priority scan; later equal level loses to earlier
  always @* begin
    best_lvl = 3'h0;
    best_vec = 8'h00;
    best_bp  = 1'b0;
    l        = 3'h0;
    v        = 8'h00;
    for (k = 0; k < `LIC_NSRC; k = k + 1) begin
      l = i_src_lvl[k*3 +: 3];
      v = src_vec_eff[k*8 +: 8];
      if (src_live[k] && l > best_lvl) begin
        best_lvl = l;
        best_vec = v;
        best_bp  = 1'b0;
      end
    end
    for (k = 7; k >= 1; k = k - 1) begin
      if (i_bp_irq[k] && i_bp_irq_en[k] && k > best_lvl) begin
        best_lvl = k[2:0];
        best_vec = 8'h00;
        best_bp  = 1'b1;
      end
    end
  end

  // presentation is held until acknowledged unless a higher level arrives or a shown backplane level loses its enable
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cpu_ipl <= 3'h0;
      o_cpu_vec <= 8'h00;
      o_cpu_bp  <= 1'b0;
    end else if (i_iack) begin
      // withdrawn for one cycle; a source still pending is shown again after that
      o_cpu_ipl <= 3'h0;
      o_cpu_vec <= 8'h00;
      o_cpu_bp  <= 1'b0;
    end else if (o_cpu_ipl == 3'h0 || best_lvl > o_cpu_ipl || bp_gone) begin
      o_cpu_ipl <= best_lvl;
      o_cpu_vec <= best_vec;
      o_cpu_bp  <= best_bp;
    end
  end

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fail_stat <= 2'h0;
      o_led       <= 6'h00;
    end else begin
      o_fail_stat <= {~i_sysfail_b, ~i_acfail_b};
      o_led       <= i_led_set;
    end
  end

  // expiry is the one-to-zero step; kept apart so it can beat a same-cycle ack
  assign tmr_expire = i_tmr_run && !i_tmr_load && pre == 5'h00 &&
                      o_tmr_count == 24'h000001;

  // timer: prescaler then down counter; expiry sets sticky event, set beats ack
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre         <= 5'h00;
      o_tmr_count <= 24'h000000;
      o_tmr_event <= 1'b0;
    end else begin
      if (i_tmr_load) begin
        pre         <= i_tmr_prescale;
        o_tmr_count <= i_tmr_preset;
      end else if (i_tmr_run && o_tmr_count != 24'h000000) begin
        if (pre == 5'h00) begin
          pre         <= i_tmr_prescale;
          o_tmr_count <= o_tmr_count - 24'h000001;
        end else begin
          pre <= pre - 5'h01;
        end
      end
      if (tmr_expire)
        o_tmr_event <= 1'b1;
      else if (i_tmr_ack)
        o_tmr_event <= 1'b0;
    end
  end

  // bus ownership with four release policies
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bus_own <= 1'b0;
      release_after_timeout       <= 8'h00;
    end else if (!o_bus_own) begin
      release_after_timeout <= 8'h00;
      if (i_bus_want && !i_arb_busy) o_bus_own <= 1'b1;
    end else begin
      // timeout count saturates so a long hold cannot wrap and re-arm
      release_after_timeout <= (release_after_timeout == `LIC_RAT_CYCLES) ? release_after_timeout : release_after_timeout + 8'h01;
      case (i_rel_mode)
        `LIC_REL_ON_REQ:    if (i_bus_done && i_bus_req_other) o_bus_own <= 1'b0;
        `LIC_REL_ON_CLEAR:  if (i_bus_done && i_bus_clear) o_bus_own <= 1'b0;
        `LIC_REL_TIMEOUT:   if (i_bus_done && release_after_timeout == `LIC_RAT_CYCLES) o_bus_own <= 1'b0;
        `LIC_REL_WHEN_DONE: if (i_bus_done) o_bus_own <= 1'b0;
        default:            o_bus_own <= 1'b0;
      endcase
    end
  end

  // single-level arbiter: grant needs system controller and request; taken only while bus idle, then held while busy
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      o_arb_grant <= 1'b0;
    else
      o_arb_grant <= i_sysctl && i_arb_req && (o_arb_grant || !i_arb_busy);
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_intr
      // ack beats a same-cycle request so a stale level is never left up
      always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b)
          o_int_irq_lvl[g*7 +: 7] <= 7'h00;
        else if (i_int_ack[g])
          o_int_irq_lvl[g*7 +: 7] <= 7'h00;
        else if (i_int_req[g] && i_int_lvl[g*3 +: 3] != 3'h0)
          o_int_irq_lvl[g*7 +: 7] <= 7'h01 << (i_int_lvl[g*3 +: 3] - 3'h1);
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [logic/lic_map.vh]
// Purpose: constants for the local interrupt and bus control block
// Assumes: one 100 MHz core clock
// Notes:   source indices, bus release mode codes and timer widths
`ifndef LIC_MAP_VH
`define LIC_MAP_VH
`define LIC_NSRC          8
`define LIC_SRC_ABORT     3'h0
`define LIC_SRC_TIMER     3'h1
`define LIC_SRC_SER1      3'h2
`define LIC_SRC_SER2      3'h3
`define LIC_SRC_DMA       3'h4
`define LIC_SRC_ACFAIL    3'h5
`define LIC_SRC_SYSFAIL   3'h6
`define LIC_SRC_SECBUS    3'h7
`define LIC_REL_ON_REQ    2'h0
`define LIC_REL_ON_CLEAR  2'h1
`define LIC_REL_TIMEOUT   2'h2
`define LIC_REL_WHEN_DONE 2'h3
`define LIC_TMR_W         24
`define LIC_PRE_W         5
`define LIC_LED_W         6
`define LIC_RAT_CYCLES    8'hFF
`endif

// [test/lic_assertions.sv]
// Purpose: port-level checks for lic_top
// Assumes: one clock, async active-low reset
// Notes:   bound to lic_top from tb
`default_nettype none
module lic_chk (
  input wire logic        i_core_clk, i_rst_b, i_tmr_run, i_tmr_load, i_acfail_b,
  input wire logic        i_sysfail_b, i_sysctl, i_arb_req, i_arb_busy, i_bus_want,
  input wire logic [5:0]  i_led_set, i_int_lvl, o_led,
  input wire logic [1:0]  i_int_req, i_int_ack, o_fail_stat,
  input wire logic [7:1]  i_bp_irq_en,
  input wire logic [2:0]  o_cpu_ipl,
  input wire logic [7:0]  o_cpu_vec,
  input wire logic [23:0] o_tmr_count,
  input wire logic [13:0] o_int_irq_lvl,
  input wire logic        o_cpu_bp, o_tmr_event, o_bus_own, o_arb_grant
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic [7:0] en_ext;
  assign en_ext = {i_bp_irq_en, 1'b0};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  property p_led; $past(i_rst_b) |-> o_led == $past(i_led_set); endproperty
  a_led: assert property (p_led) else $error("lights lag");
  property p_fail; $past(i_rst_b) |-> o_fail_stat == ~$past({i_sysfail_b, i_acfail_b});
  endproperty
  a_fail: assert property (p_fail) else $error("fail status wrong");
  property p_arb; $past(i_rst_b) |->
    o_arb_grant == $past(i_sysctl && i_arb_req && (o_arb_grant || !i_arb_busy)); endproperty
  a_arb: assert property (p_arb) else $error("grant wrong");
  property p_int; i_int_req[0] && !i_int_ack[0] && i_int_lvl[2:0] != 3'h0
    |=> o_int_irq_lvl[$past(i_int_lvl[2:0]) - 3'h1]; endproperty
  a_int: assert property (p_int) else $error("interrupter level missing");
  property p_int_ack; i_int_ack[1] |=> o_int_irq_lvl[13:7] == 7'h00; endproperty
  a_int_ack: assert property (p_int_ack) else $error("interrupter not cleared");
  property p_tmr_evt; !$past(i_tmr_load) && $past(o_tmr_count) == 24'h1 && o_tmr_count == 24'h0
    |-> o_tmr_event; endproperty
  a_tmr_evt: assert property (p_tmr_evt) else $error("no expiry event");
  property p_tmr_hold; !i_tmr_run && !i_tmr_load |=> $stable(o_tmr_count); endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("count moved");
  property p_bus; i_bus_want && !i_arb_busy && !o_bus_own |=> o_bus_own; endproperty
  a_bus: assert property (p_bus) else $error("bus not taken");
  property p_bpmask; !o_cpu_bp && i_bp_irq_en == 7'h00 |=> !o_cpu_bp; endproperty
  a_bpmask: assert property (p_bpmask) else $error("disabled level shown");
  property p_bpdrop; o_cpu_bp && !en_ext[o_cpu_ipl]
    |=> !o_cpu_bp || o_cpu_ipl != $past(o_cpu_ipl); endproperty
  a_bpdrop: assert property (p_bpdrop) else $error("withdrawn level still shown");
  property p_bpvec; o_cpu_bp |-> o_cpu_vec == 8'h00 && o_cpu_ipl != 3'h0; endproperty
  a_bpvec: assert property (p_bpvec) else $error("backplane vector wrong");
  c_bp: cover property (o_cpu_bp);
  c_tmr: cover property (o_tmr_event);
  c_int: cover property (o_int_irq_lvl[13:7] != 7'h00);
endmodule
`default_nettype wire

// [test/lic_cpu.sv]
// Purpose: processor side that acknowledges a presented interrupt
// Assumes: acknowledges only while i_go is high, so the bench sets the latency
// Notes:   one-cycle pulse, never two in a row
`default_nettype none
module lic_cpu (
  input  wire logic       i_core_clk, i_rst_b, i_go,
  input  wire logic [2:0] i_ipl,
  output var  logic       o_iack
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge i_core_clk or negedge i_rst_b)
    if (!i_rst_b) o_iack <= 1'b0;
    else o_iack <= i_go && i_ipl != 3'h0 && !o_iack;
endmodule
`default_nettype wire

// [test/tb.sv]
// Purpose: directed bench for lic_top
// Assumes: outputs read at an edge, before that edge's updates land
// Notes:   expectations come from the bench's own settings
`include "lic_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk = 0, i_rst_b = 0, i_tmr_load = 0, i_tmr_run = 0, i_tmr_ack = 0, go = 0;
  logic i_bus_want = 0, i_bus_done = 0, i_bus_clear = 0, i_bus_req_other = 0, i_sysctl = 0;
  logic i_arb_req = 0, i_arb_busy = 0, i_acfail_b = 1, i_sysfail_b = 1;
  logic [7:0] i_src_req = 0;
  logic [1:0] i_ser1_cause = 0, i_ser2_cause = 0, i_rel_mode = 0, i_int_req = 0, i_int_ack = 0;
  logic [23:0] i_src_lvl = 0, i_tmr_preset = 0;
  logic [63:0] i_src_vec = 64'h1716151413121110;
  logic [31:0] i_ser_vec = 32'hD4C3B2A1;
  logic [7:1] i_bp_irq = 0, i_bp_irq_en = 0;
  logic [5:0] i_led_set = 0, i_int_lvl = 0, o_led;
  logic [4:0] i_tmr_prescale = 0;
  logic [2:0] o_cpu_ipl;
  logic [7:0] o_cpu_vec;
  logic [1:0] o_fail_stat;
  logic [23:0] o_tmr_count;
  logic [13:0] o_int_irq_lvl;
  logic o_cpu_bp, o_tmr_event, o_bus_own, o_arb_grant;
  wire logic i_iack;
  int errors = 0, total_checks = 0, s, c, k;
  lic_top dut (.*);
  lic_cpu u_cpu (.i_core_clk, .i_rst_b, .i_go(go), .i_ipl(o_cpu_ipl), .o_iack(i_iack));
  always #5 i_core_clk = ~i_core_clk;
  task cyc(input int n); repeat (n) @(posedge i_core_clk); endtask
  task chk(input logic [63:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task lim(input int n);
    if (n >= 400) begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      test_done;
    end
  endtask
  // the partner only acknowledges while go is high
  task ack; go <= 1; cyc(1); go <= 0; cyc(3); chk(o_cpu_ipl, 0); endtask
  initial begin
    cyc(4); i_rst_b <= 1; cyc(2);
    chk({o_cpu_ipl, o_cpu_vec, o_fail_stat, o_tmr_count, o_int_irq_lvl, o_bus_own}, 0);
    for (s = 0; s < 8; s++) for (c = 0; c < ((s == 2 || s == 3) ? 3 : 1); c++) if (s != 1) begin
      i_src_lvl <= 24'h5 << (3 * s); i_src_req <= 8'h1 << s;
      i_ser1_cause <= c[1:0]; i_ser2_cause <= c[1:0]; cyc(2);
      chk({o_cpu_ipl, o_cpu_bp}, {3'h5, 1'b0});
      chk(o_cpu_vec, c == 0 ? 8'h10 + s : 8'(i_ser_vec >> (8 * (2 * s - 5 + c))));
      i_src_req <= 0; ack;
    end
    $display("local routing done");
    i_src_lvl <= 24'h6 << 12 | 24'h2; i_src_req <= 8'h11; cyc(2);
    chk({o_cpu_ipl, o_cpu_vec}, {3'h6, 8'h14});
    i_src_req <= 0; i_src_lvl <= 0; ack;
    i_bp_irq <= 7'h7F; i_bp_irq_en <= 7'h04; cyc(2);
    chk({o_cpu_ipl, o_cpu_vec, o_cpu_bp}, {3'h3, 8'h00, 1'b1});
    i_bp_irq_en <= 0; ack; i_bp_irq <= 0;
    i_led_set <= 6'h2A; i_acfail_b <= 0; cyc(2);
    chk({o_led, o_fail_stat}, {6'h2A, 2'h1});
    i_sysfail_b <= 0; i_acfail_b <= 1; cyc(2); chk(o_fail_stat, 2'h2);
    i_sysfail_b <= 1; $display("routing and lights done");
    for (c = 0; c < 32; c += 31) begin
      i_tmr_preset <= 3; i_tmr_prescale <= c[4:0]; i_tmr_load <= 1; i_tmr_run <= 1;
      i_src_lvl <= 24'h5 << 3; cyc(1);
      i_tmr_load <= 0;
      for (k = 0; k < 400 && o_tmr_event !== 1'b1; k++) cyc(1);
      lim(k); chk({k, o_tmr_count}, {3 * (c + 1) + 1, 24'h0});
      cyc(1); chk({o_cpu_ipl, o_cpu_vec}, {3'h5, 8'h11});
      i_tmr_run <= 0; i_tmr_ack <= 1; cyc(1); i_tmr_ack <= 0; cyc(2);
      chk(o_tmr_event, 0);
      i_src_lvl <= 0; ack;
    end
    $display("timer done");
    for (c = 0; c < 4; c++) begin
      i_rel_mode <= c[1:0]; i_bus_want <= 1; cyc(2); chk(o_bus_own, 1);
      i_bus_want <= 0; i_bus_done <= 1; i_bus_req_other <= 1; i_bus_clear <= 1;
      for (k = 0; k < 400 && o_bus_own !== 1'b0; k++) cyc(1);
      lim(k); chk(k, c == 2 ? `LIC_RAT_CYCLES + 1 : 2);
      i_bus_done <= 0; i_bus_req_other <= 0; i_bus_clear <= 0; cyc(1);
    end
    i_sysctl <= 1; i_arb_req <= 1; cyc(2); chk(o_arb_grant, 1);
    i_arb_busy <= 1; cyc(2); chk(o_arb_grant, 1);
    i_arb_req <= 0; cyc(2); chk(o_arb_grant, 0);
    $display("bus and arbiter done");
    i_int_lvl <= 6'h15; i_int_req <= 2'h3; cyc(1); i_int_req <= 0; cyc(1);
    chk(o_int_irq_lvl, 14'h0110);
    i_int_ack <= 2'h3; cyc(1); i_int_ack <= 0; cyc(1); chk(o_int_irq_lvl, 0);
    $display("interrupters done");
    test_done;
  end
endmodule
bind lic_top lic_chk u_chk (.*);
`default_nettype wire
